// ==== common/rce_pkg.sv ====
// shared constants and carrier types for the resource-conflict exception unit
package rce_pkg;

    // ==========================================================
    // structure
    localparam int N_SLOTS    = 2;
    localparam int N_PRED     = 4;
    localparam int DEST_W     = 5;
    localparam int CREG_W     = 2;

    // ==========================================================
    // drain timing: annulled packets flushed per interrupt
    localparam int           DRAIN_PKTS = 4;
    localparam logic [2:0]   DRAIN_LAST = 3'(DRAIN_PKTS - 1);

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0]   OFF_CTRL   = 8'h00;
    localparam logic [7:0]   OFF_ERR_STAT   = 8'h04;
    localparam logic [7:0]   OFF_EXC_FLAG   = 8'h08;
    localparam logic [7:0]   OFF_EXC_CLR    = 8'h0C;
    localparam logic [7:0]   OFF_RET_PTR    = 8'h10;
    localparam logic [7:0]   OFF_TASK_STATE = 8'h14;
    localparam logic [7:0]   OFF_STAT   = 8'h18;

    // ==========================================================
    // field positions
    localparam int CTRL_LEGACY_BIT = 0;
    localparam int ERR_CONFLICT_BIT  = 4;
    localparam int FLAG_INTERNAL_BIT = 1;
    localparam int TASK_LOOP_BIT     = 1;
    localparam int TASK_INT_BIT      = 3;
    localparam int TASK_MODE_LSB     = 6;
    localparam int TASK_BLOCKED_BIT  = 16;
    localparam int STAT_DRAIN_BIT  = 0;
    localparam int STAT_PEND_BIT   = 1;

    // ==========================================================
    // reset values
    localparam logic [31:0]  CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0]  ERR_STAT_RST   = 32'h0000_0000;
    localparam logic [31:0]  EXC_FLAG_RST   = 32'h0000_0000;
    localparam logic [31:0]  RET_PTR_RST    = 32'h0000_0000;
    localparam logic [31:0]  TASK_STATE_RST = 32'h0000_0000;
    localparam logic [31:0]  ZERO_WORD  = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic                valid;
        logic                pred_en;
        logic [CREG_W-1:0]   creg;
        logic                cinv;
        logic [DEST_W-1:0]   dest;
    } rce_slot_t;

    typedef struct packed {
        logic                        valid;
        logic [31:0]                 pc;
        logic [N_PRED-1:0]           pred_we;
        logic [N_PRED-1:0]           pred_wdata;
        rce_slot_t [N_SLOTS-1:0]     slot;
    } rce_pkt_t;

    typedef struct packed {
        logic         psel;
        logic         penable;
        logic         pwrite;
        logic [7:0]   paddr;
        logic [31:0]  pwdata;
    } rce_apb_req_t;

    typedef struct packed {
        logic         pready;
        logic [31:0]  prdata;
        logic         pslverr;
    } rce_apb_rsp_t;

endpackage : rce_pkg

// ==== hdl/rce_conflict_unit.sv ====
// resource-conflict exception unit: drain, annulment, detection, state capture, apb registers
// Summary of operation
// - on interrupt, drain the pipeline and annul all in-flight packets, in legacy and corrected mode alike.
// - legacy mode examines packets during flush even though they are annulled.
// - raise exception when two writes to one register use different condition registers.
// - annulled predicate writes feed the next annulled packet's conditions in legacy mode.
// - spurious exception pends during drain and is taken on reaching the handler.
// - on a drain exception, return pointer and task state capture the state at handler arrival; a real conflict captures its own pc.
// - exception never alters commits or results; only flags and capture change.
//
// The address map and the APB interface to the registers were chosen for this implementation.
module rce_conflict_unit
    import rce_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire rce_apb_req_t         apb_req,
    output rce_apb_rsp_t              apb_rsp,
    input  wire rce_pkt_t             pkt_in,
    input  wire logic                 irq_req,
    input  wire logic [31:0]          handler_pc,
    input  wire logic                 loop_active,
    input  wire logic                 irq_blocked,
    input  wire logic [1:0]           ctx_mode,
    output logic [N_SLOTS-1:0]        commit_en,
    output logic                      drain_busy,
    output logic                      handler_arrive,
    output logic                      exc_take
);

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        RCE_RUN   = 2'b01,
        RCE_DRAIN = 2'b10
    } rce_state_t;

    rce_state_t         state;
    rce_state_t         next_state;
    logic [2:0]         cnt;
    logic [2:0]         next_cnt;
    logic               pend;
    logic               next_pend;
    logic [N_PRED-1:0]  last_we;
    logic [N_PRED-1:0]  next_last_we;
    logic [N_PRED-1:0]  last_wd;
    logic [N_PRED-1:0]  next_last_wd;
    logic [31:0]        ctrl;
    logic [31:0]        next_ctrl;
    logic [31:0]        internal_error_status;
    logic [31:0]        next_internal_error_status;
    logic [31:0]        exception_flag_status;
    logic [31:0]        next_exception_flag_status;
    logic [31:0]        nmi_return_pointer;
    logic [31:0]        next_nmi_return_pointer;
    logic [31:0]        nmi_task_state;
    logic [31:0]        next_nmi_task_state;
    rce_apb_rsp_t       next_rsp;
    logic [N_SLOTS-1:0] next_commit;
    logic               next_arrive;
    logic               next_take;

    logic               annul;
    logic               legacy;
    logic [N_PRED-1:0]  arch_pred;
    logic [N_PRED-1:0]  shadow_pred;
    logic [N_PRED-1:0]  arch_we;
    logic [N_SLOTS-1:0] exec_lg;
    logic [N_SLOTS-1:0] exec_fx;
    logic               conf_lg;
    logic               conf_fx;
    logic               spur_det;
    logic               real_det;
    logic               arrive_now;
    logic               take_spur;
    logic               wr_en;
    logic [31:0]        rd_mux;
    logic               rd_err;

    assign annul  = (state == RCE_DRAIN);
    assign legacy = ctrl[CTRL_LEGACY_BIT];

    // ==========================================================
    // predicates: committed file plus the view that includes annulled writes
    assign arch_we = (pkt_in.valid && !annul) ? pkt_in.pred_we : '0;

    rce_pred_file u_pred (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (arch_we),
        .wdata   (pkt_in.pred_wdata),
        .pred    (arch_pred)
    );

    // the previous packet's predicate writes, annulled or not, as the faulty logic sees them
    assign shadow_pred = (last_we & last_wd) | (~last_we & arch_pred);

    genvar g;
    for (g = 0; g < N_SLOTS; g++) begin : g_slot
        assign exec_lg[g] = pkt_in.slot[g].valid &&
                            (!pkt_in.slot[g].pred_en ||
                             (shadow_pred[pkt_in.slot[g].creg] ^ pkt_in.slot[g].cinv));
        assign exec_fx[g] = pkt_in.slot[g].valid &&
                            (!pkt_in.slot[g].pred_en ||
                             (arch_pred[pkt_in.slot[g].creg] ^ pkt_in.slot[g].cinv));
    end

    // ==========================================================
    // conflict detection: same destination, two different guarding registers
    always_comb begin
        conf_lg = 1'b0;
        conf_fx = 1'b0;
        if (pkt_in.valid && pkt_in.slot[0].pred_en && pkt_in.slot[1].pred_en &&
            (pkt_in.slot[0].dest == pkt_in.slot[1].dest) &&
            (pkt_in.slot[0].creg != pkt_in.slot[1].creg)) begin
            conf_lg = &exec_lg;
            conf_fx = &exec_fx;
        end
    end

    // legacy evaluates even annulled packets; corrected mode drops them entirely
    assign spur_det   = annul && legacy && conf_lg;
    assign real_det   = !annul && (legacy ? conf_lg : conf_fx);
    assign arrive_now = annul && (cnt == 3'h0);
    assign take_spur  = arrive_now && (pend || spur_det);

    // ==========================================================
    // drain sequencing and pipeline-facing outputs
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_pend    = pend;
        next_last_we = pkt_in.valid ? pkt_in.pred_we : '0;
        next_last_wd = pkt_in.pred_wdata;
        next_arrive  = arrive_now;
        next_commit  = (pkt_in.valid && !annul) ? exec_fx : '0;
        case (state)
            RCE_RUN: begin
                next_pend = 1'b0;
                if (irq_req) begin
                    next_state = RCE_DRAIN;
                    next_cnt   = DRAIN_LAST;
                end
            end
            RCE_DRAIN: begin
                next_pend = pend || spur_det;
                next_cnt  = cnt - 3'h1;
                if (arrive_now) begin
                    next_state = RCE_RUN;
                    next_pend  = 1'b0;
                    next_cnt   = 3'h0;
                end
            end
            default: begin
                next_state = RCE_RUN;
                next_cnt   = 3'h0;
                next_pend  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= RCE_RUN;
            cnt            <= 3'h0;
            pend           <= 1'b0;
            last_we        <= '0;
            last_wd        <= '0;
            handler_arrive <= 1'b0;
            commit_en      <= '0;
        end else begin
            state          <= next_state;
            cnt            <= next_cnt;
            pend           <= next_pend;
            last_we        <= next_last_we;
            last_wd        <= next_last_wd;
            handler_arrive <= next_arrive;
            commit_en      <= next_commit;
        end
    end

    assign drain_busy = state[1]; // one-hot drain bit, so the pin comes straight from a flop

    // ==========================================================
    // exception flags and state capture
    assign wr_en = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;

    always_comb begin
        next_ctrl                  = ctrl;
        next_internal_error_status = internal_error_status;
        next_exception_flag_status = exception_flag_status;
        next_nmi_return_pointer    = nmi_return_pointer;
        next_nmi_task_state        = nmi_task_state;
        next_take                  = take_spur || real_det;
        if (wr_en && apb_req.paddr == OFF_CTRL) begin
            next_ctrl = ZERO_WORD;
            next_ctrl[CTRL_LEGACY_BIT] = apb_req.pwdata[CTRL_LEGACY_BIT];
        end
        if (wr_en && apb_req.paddr == OFF_ERR_STAT) begin
            next_internal_error_status = internal_error_status & ~apb_req.pwdata;
        end
        if (wr_en && apb_req.paddr == OFF_EXC_CLR) begin
            next_exception_flag_status = exception_flag_status & ~apb_req.pwdata;
        end
        // a new exception in the clearing cycle wins over the clear
        if (next_take) begin
            next_internal_error_status[ERR_CONFLICT_BIT] = 1'b1;
            next_exception_flag_status[FLAG_INTERNAL_BIT] = 1'b1;
            next_nmi_task_state = ZERO_WORD;
            next_nmi_task_state[TASK_LOOP_BIT]      = loop_active;
            next_nmi_task_state[TASK_BLOCKED_BIT]   = irq_blocked;
            next_nmi_task_state[TASK_MODE_LSB +: 2] = ctx_mode;
            if (take_spur) begin
                next_nmi_return_pointer = handler_pc;
                next_nmi_task_state[TASK_INT_BIT] = 1'b1;
            end else begin
                next_nmi_return_pointer = pkt_in.pc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                  <= CTRL_RST;
            internal_error_status <= ERR_STAT_RST;
            exception_flag_status <= EXC_FLAG_RST;
            nmi_return_pointer    <= RET_PTR_RST;
            nmi_task_state        <= TASK_STATE_RST;
            exc_take              <= 1'b0;
        end else begin
            ctrl                  <= next_ctrl;
            internal_error_status <= next_internal_error_status;
            exception_flag_status <= next_exception_flag_status;
            nmi_return_pointer    <= next_nmi_return_pointer;
            nmi_task_state        <= next_nmi_task_state;
            exc_take              <= next_take;
        end
    end

    // ==========================================================
    // apb slave: data prepared in setup, answered in the first access cycle
    always_comb begin
        rd_err = 1'b0;
        rd_mux = ZERO_WORD;
        case (apb_req.paddr)
            OFF_CTRL: rd_mux = ctrl;
            OFF_ERR_STAT:   rd_mux = internal_error_status;
            OFF_EXC_FLAG:   rd_mux = exception_flag_status;
            OFF_EXC_CLR:    rd_mux = ZERO_WORD;
            OFF_RET_PTR:    rd_mux = nmi_return_pointer;
            OFF_TASK_STATE: rd_mux = nmi_task_state;
            OFF_STAT: begin
                rd_mux[STAT_DRAIN_BIT] = annul;
                rd_mux[STAT_PEND_BIT]  = pend;
            end
            default:  rd_err = 1'b1;
        endcase
    end

    always_comb begin
        next_rsp = '0;
        if (apb_req.psel && !apb_req.penable) begin
            next_rsp.pready  = 1'b1;
            next_rsp.pslverr = rd_err;
            next_rsp.prdata  = apb_req.pwrite ? ZERO_WORD : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp <= next_rsp;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_drain_done;
        drain_busy [*4] ##1 (handler_arrive && !drain_busy);
    endsequence

    sequence s_spur_seen;
        drain_busy && legacy && spur_det;
    endsequence

    property p_drain;
        (irq_req && !drain_busy) |=> s_drain_done;
    endproperty
    a_drain: assert property (p_drain) else $error("drain length or arrival wrong");

    property p_annul;
        drain_busy |=> (commit_en == '0);
    endproperty
    a_annul: assert property (p_annul) else $error("commit during drain");

    property p_legacy;
        s_spur_seen |-> ##[1:4] (exc_take && handler_arrive);
    endproperty
    a_legacy: assert property (p_legacy) else $error("spurious case not raised at arrival");

    property p_real;
        real_det |=> (exc_take && nmi_return_pointer == $past(pkt_in.pc));
    endproperty
    a_real: assert property (p_real) else $error("conflict not raised with its pc");

    property p_flags;
        exc_take |-> (exception_flag_status[FLAG_INTERNAL_BIT] && internal_error_status[ERR_CONFLICT_BIT]);
    endproperty
    a_flags: assert property (p_flags) else $error("exception flags not set");

    property p_fixed;
        (drain_busy && !legacy) |=> !exc_take;
    endproperty
    a_fixed: assert property (p_fixed) else $error("corrected mode saw an annulled conflict");

    property p_arrive;
        (exc_take && nmi_task_state[TASK_INT_BIT]) |-> handler_arrive;
    endproperty
    a_arrive: assert property (p_arrive) else $error("drain exception taken before arrival");

    property p_capture;
        (exc_take && handler_arrive) |-> (nmi_return_pointer == $past(handler_pc)) &&
                                         (nmi_task_state[TASK_MODE_LSB +: 2] == $past(ctx_mode));
    endproperty
    a_capture: assert property (p_capture) else $error("state not captured at arrival");

    property p_flow;
        (!drain_busy && pkt_in.valid && pkt_in.slot[0].valid && !pkt_in.slot[0].pred_en) |=> commit_en[0];
    endproperty
    a_flow: assert property (p_flow) else $error("unconditional slot not committed");

endmodule // rce_conflict_unit

// ==== hdl/rce_pred_file.sv ====
// committed predicate register file, one flop per predicate
module rce_pred_file
    import rce_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [N_PRED-1:0]    we,
    input  wire logic [N_PRED-1:0]    wdata,
    output logic      [N_PRED-1:0]    pred
);

    logic [N_PRED-1:0] next_pred;

    // ==========================================================
    // per-predicate update
    genvar g;
    for (g = 0; g < N_PRED; g++) begin : g_pred
        always_comb begin
            next_pred[g] = we[g] ? wdata[g] : pred[g];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pred[g] <= 1'b0;
            end else begin
                pred[g] <= next_pred[g];
            end
        end
    end

endmodule // rce_pred_file

// ==== verif/rce_conflict_unit_tb.sv ====
// self-checking bench for the resource-conflict exception unit
module rce_conflict_unit_tb
    import rce_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ====================
    // signals
    logic          pclk = 1'b0;
    logic          presetn;
    rce_apb_req_t  req;
    rce_apb_rsp_t  rsp;
    rce_pkt_t      pkt;
    rce_pkt_t      no_pkt = '0;
    logic          irq_req;
    logic [31:0]   hpc;
    logic          loop_act;
    logic          irq_blk;
    logic [1:0]    ctx;
    logic [1:0]    commit_en;
    logic          drain_busy;
    logic          handler_arrive;
    logic          exc_take;
    logic [32:0]   exp_q[$];
    int            bad_count = 0;
    int            total_checks = 0;
    int            seed = 50857;
    logic [31:0]   pcv;
    logic [4:0]    dst;

    always #50 pclk = ~pclk;

    rce_conflict_unit rce_conflict_unit_i (
        .pclk           (pclk),
        .presetn        (presetn),
        .apb_req        (req),
        .apb_rsp        (rsp),
        .pkt_in         (pkt),
        .irq_req        (irq_req),
        .handler_pc     (hpc),
        .loop_active    (loop_act),
        .irq_blocked    (irq_blk),
        .ctx_mode       (ctx),
        .commit_en      (commit_en),
        .drain_busy     (drain_busy),
        .handler_arrive (handler_arrive),
        .exc_take       (exc_take)
    );

    // ====================
    // helpers
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // entered and left just after a rising edge; the extra idle edge keeps psel from
    // being assigned twice in one time step when calls follow each other
    // no local limit on the wait: a slave that never answers is caught by the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, ZERO_WORD, {1'b0, v});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, {1'b0, ZERO_WORD});
    endtask

    // s = {slot0 valid, slot0 invert, slot1 valid, slot1 creg, slot1 invert}; slot0 uses creg 0
    function automatic rce_pkt_t mk(input logic [5:0] s, input logic [4:0] d1,
                                    input logic [3:0] we, input logic [3:0] wd);
        rce_pkt_t p;
        p = '0;
        p.valid = 1'b1;
        p.pc = pcv;
        p.pred_we = we;
        p.pred_wdata = wd;
        p.slot[0] = '{s[5], 1'b1, 2'b00, s[4], dst};
        p.slot[1] = '{s[3], 1'b1, s[2:1], s[0], d1};
        return p;
    endfunction

    task automatic step(input rce_pkt_t p, input logic [1:0] ce, input logic tk);
        pkt <= p;
        @(posedge pclk);
        pkt <= no_pkt;
        @(negedge pclk);
        check({30'h0, exc_take, commit_en}, {30'h0, tk, ce});
        @(posedge pclk);
    endtask

    // irq held into the drain must be ignored; an annulled packet writes p0, the next
    // annulled one only conflicts if that write is wrongly seen; a probe then reads p0
    task automatic drain(input logic lg);
        rce_pkt_t pa;
        rce_pkt_t pb;
        rce_pkt_t pr;
        pa = mk(6'b000000, dst, 4'b0001, 4'b0001);
        pb = mk(6'b101011, dst, 4'b0000, 4'b0000);
        pr = mk(6'b100000, dst, 4'b0000, 4'b0000);
        irq_req <= 1'b1;
        for (int k = 1; k <= 7; k++) begin
            @(posedge pclk);
            irq_req <= (k <= 2);
            pkt <= (k == 1) ? pa : (k == 2) ? pb : (k == 6) ? pr : no_pkt;
            @(negedge pclk);
            check({28'h0, drain_busy, handler_arrive, exc_take, commit_en},
                  {28'h0, k <= 4, k == 5, lg && k == 5, 2'b00});
        end
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("BAD t=%0t unexpected pready", $time);
            end else begin
                check({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
            end
        end
    end

    // ====================
    // tests
    initial begin
        presetn = 1'b0;
        req = '0;
        pkt = '0;
        irq_req = 1'b0;
        loop_act = 1'b0;
        irq_blk = 1'b0;
        ctx = 2'b00;
        pcv = 32'($random(seed));
        dst = 5'($random(seed));
        hpc = 32'($random(seed));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), ZERO_WORD);
        end
        apb(1'b0, 8'h1C, ZERO_WORD, {1'b1, ZERO_WORD});
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF, {1'b1, ZERO_WORD});
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_CTRL, 32'h0000_0001);
        wr(OFF_CTRL, ZERO_WORD);
        wr(OFF_RET_PTR, 32'hFFFF_FFFF);
        rd(OFF_RET_PTR, ZERO_WORD);
        $display("test registers done");

        loop_act <= 1'b1;
        irq_blk <= 1'b1;
        ctx <= 2'b10;
        for (int k = 0; k < 3; k++) begin
            step(mk({3'b111, 1'b0, k != 0, 1'b1}, (k == 1) ? dst + 5'd1 : dst, 4'h0, 4'h0), 2'b11, k == 2);
        end
        rd(OFF_ERR_STAT, 32'h0000_0001 << ERR_CONFLICT_BIT);
        rd(OFF_EXC_FLAG, 32'h0000_0001 << FLAG_INTERNAL_BIT);
        rd(OFF_RET_PTR, pcv);
        rd(OFF_TASK_STATE, (32'h0000_0001 << TASK_LOOP_BIT) | (32'h0000_0002 << TASK_MODE_LSB)
                           | (32'h0000_0001 << TASK_BLOCKED_BIT));
        wr(OFF_EXC_CLR, 32'h0000_0002);
        rd(OFF_EXC_FLAG, ZERO_WORD);
        wr(OFF_ERR_STAT, 32'h0000_0001 << ERR_CONFLICT_BIT);
        rd(OFF_ERR_STAT, ZERO_WORD);
        loop_act <= 1'b0;
        irq_blk <= 1'b0;
        ctx <= 2'b00;
        $display("test real conflict done");

        drain(1'b0);
        rd(OFF_ERR_STAT, ZERO_WORD);
        rd(OFF_EXC_FLAG, ZERO_WORD);
        step(mk(6'b000000, dst, 4'b0001, 4'b0001), 2'b00, 1'b0);
        step(mk(6'b100000, dst, 4'b0000, 4'b0000), 2'b01, 1'b0);
        step(mk(6'b000000, dst, 4'b0001, 4'b0000), 2'b00, 1'b0);
        $display("test corrected drain done");

        wr(OFF_CTRL, 32'h0000_0001);
        drain(1'b1);
        rd(OFF_ERR_STAT, 32'h0000_0001 << ERR_CONFLICT_BIT);
        rd(OFF_EXC_FLAG, 32'h0000_0001 << FLAG_INTERNAL_BIT);
        rd(OFF_RET_PTR, hpc);
        rd(OFF_TASK_STATE, 32'h0000_0001 << TASK_INT_BIT);
        wr(OFF_EXC_CLR, 32'h0000_0002);
        rd(OFF_EXC_FLAG, ZERO_WORD);
        rd(OFF_STAT, ZERO_WORD);
        $display("test legacy drain done");
        give_verdict();
    end

    // the whole sequence needs about 130 cycles; over twenty times that means a hang
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end

endmodule // rce_conflict_unit_tb
